// ---- rtl/memory_board_bank_select_protect.sv ----
`timescale 1ns/1ps
`default_nettype none
module memory_board_bank_select_protect (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// backplane
	input  wire logic [3:0]   addr_hi_i,
	input  wire logic         mem_read_i,
	input  wire logic         mem_write_i,
	input  wire logic         output_cycle_i,
	input  wire logic         alternate_bank_select_n_i,
	input  wire logic         conditional_write_line_i,
	// memory array controls
	output logic [3:0]        bank_select_n_o,
	output logic [3:0]        bank_write_o,
	output logic              data_out_en_o,
	output logic              map_conflict_o,
	// axi4-lite slave
	input  wire logic [3:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [3:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready
);
	logic [31:0] config_reg;
	logic [31:0] map_reg;
	logic        seen_reg;
	logic [3:0]  hit;
	logic [3:0]  pos [4];
	logic        multi_hit;
	logic        conflict;
	logic        decoder_disable;
	logic        card_enable;
	logic        access;
	logic        card_sel;
	logic        wr_fire;
	logic        seen_clear;
	logic [31:0] status_word;

	// per bank block compare
	genvar b;
	generate
		for (b = 0; b < bank_select_pkg::NUM_BANKS; b++) begin : g_bank
			assign pos[b] = map_reg[b*bank_select_pkg::POS_W +: bank_select_pkg::POS_W];
			assign hit[b] = config_reg[bank_select_pkg::CFG_MAPPED_LSB + b] && (pos[b] == addr_hi_i);
		end
	endgenerate

	// any two mapped banks on one block
	always_comb begin
		conflict = 1'b0;
		for (int i = 0; i < bank_select_pkg::NUM_BANKS; i++) begin
			for (int j = i + 1; j < bank_select_pkg::NUM_BANKS; j++) begin
				if (config_reg[bank_select_pkg::CFG_MAPPED_LSB + i] && config_reg[bank_select_pkg::CFG_MAPPED_LSB + j]
					&& pos[i] == pos[j]) begin
					conflict = 1'b1;
				end
			end
		end
	end

	assign multi_hit       = (hit & (hit - 4'h1)) != 4'h0;
	assign decoder_disable = config_reg[bank_select_pkg::CFG_ALT_BIT] ? alternate_bank_select_n_i : 1'b0;
	assign card_enable     = !decoder_disable && !output_cycle_i;
	assign access          = mem_read_i || mem_write_i;
	assign card_sel        = card_enable && access && (hit != 4'h0) && !multi_hit;

	// chip selects and write strobes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bank_select_n_o <= 4'hF;
			bank_write_o    <= 4'h0;
		end else begin
			for (int i = 0; i < bank_select_pkg::NUM_BANKS; i++) begin
				bank_select_n_o[i] <= !(card_sel && hit[i]);
				bank_write_o[i]    <= card_sel && hit[i] && mem_write_i
					&& config_reg[bank_select_pkg::CFG_WRITE_LSB + i]
					&& (!config_reg[bank_select_pkg::CFG_CMW_BIT] || conditional_write_line_i);
			end
		end
	end

	// read data drive
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_out_en_o <= 1'b0;
		end else begin
			data_out_en_o <= card_sel && mem_read_i;
		end
	end

	// conflict flag
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			map_conflict_o <= 1'b0;
		end else begin
			map_conflict_o <= conflict;
		end
	end

	// axi write channel: both taken together
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= bank_select_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= wr_fire;
			s_axi_wready  <= wr_fire;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (s_axi_awaddr == bank_select_pkg::CONFIG_OFFSET
					|| s_axi_awaddr == bank_select_pkg::MAP_OFFSET
					|| s_axi_awaddr == bank_select_pkg::STATUS_OFFSET)
					? bank_select_pkg::RESP_OKAY : bank_select_pkg::RESP_DECERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// configuration and map registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			config_reg <= bank_select_pkg::CONFIG_RESET;
			map_reg    <= bank_select_pkg::MAP_RESET;
		end else if (wr_fire) begin
			for (int k = 0; k < 4; k++) begin
				if (s_axi_wstrb[k] && s_axi_awaddr == bank_select_pkg::CONFIG_OFFSET) begin
					config_reg[k*8 +: 8] <= s_axi_wdata[k*8 +: 8];
				end
				if (s_axi_wstrb[k] && s_axi_awaddr == bank_select_pkg::MAP_OFFSET) begin
					map_reg[k*8 +: 8] <= s_axi_wdata[k*8 +: 8];
				end
			end
		end
	end

	// sticky conflict seen, write one to clear, set wins
	assign seen_clear = wr_fire && s_axi_awaddr == bank_select_pkg::STATUS_OFFSET && s_axi_wstrb[0]
		&& s_axi_wdata[bank_select_pkg::ST_SEEN];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seen_reg <= 1'b0;
		end else if (conflict) begin
			seen_reg <= 1'b1;
		end else if (seen_clear) begin
			seen_reg <= 1'b0;
		end
	end

	always_comb begin
		status_word                                  = 32'h0000_0000;
		status_word[bank_select_pkg::ST_CONFLICT]    = map_conflict_o;
		status_word[bank_select_pkg::ST_ENABLED]     = card_enable;
		status_word[bank_select_pkg::ST_SEEN]        = seen_reg;
		status_word[bank_select_pkg::ST_SEL_LSB +: 4] = ~bank_select_n_o;
	end

	// axi read channel
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= bank_select_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= bank_select_pkg::RESP_OKAY;
				unique case (s_axi_araddr)
					bank_select_pkg::CONFIG_OFFSET: s_axi_rdata <= config_reg;
					bank_select_pkg::MAP_OFFSET:    s_axi_rdata <= map_reg;
					bank_select_pkg::STATUS_OFFSET: s_axi_rdata <= status_word;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= bank_select_pkg::RESP_DECERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// checks
	disable_high_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		decoder_disable |=> bank_select_n_o == 4'hF && !data_out_en_o && bank_write_o == 4'h0)
		else $error("card responded while disabled");
	default_strap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!config_reg[bank_select_pkg::CFG_ALT_BIT] && !output_cycle_i |-> card_enable)
		else $error("default strap did not keep card enabled");
	alt_strap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		config_reg[bank_select_pkg::CFG_ALT_BIT] && alternate_bank_select_n_i |-> !card_enable)
		else $error("alternate strap enabled without select");
	bank_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		card_sel && hit[2] |=> !bank_select_n_o[2] && $past(pos[2]) == $past(addr_hi_i))
		else $error("bank select does not follow its map");
	protect_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!config_reg[bank_select_pkg::CFG_WRITE_LSB] |=> !bank_write_o[0])
		else $error("protected bank written");
	output_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		output_cycle_i |=> bank_select_n_o == 4'hF)
		else $error("card selected during output cycle");
	cond_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		config_reg[bank_select_pkg::CFG_CMW_BIT] && !conditional_write_line_i |=> bank_write_o == 4'h0)
		else $error("write passed closed conditional line");
	read_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		data_out_en_o |-> $past(mem_read_i) && bank_select_n_o != 4'hF)
		else $error("data driven without selected read");
	one_select_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$countones(~bank_select_n_o) <= 1)
		else $error("more than one bank selected");
endmodule // memory_board_bank_select_protect
`default_nettype wire

// ---- rtl/bank_select_pkg.sv ----
package bank_select_pkg;
	localparam int                 NUM_BANKS      = 4;
	localparam int                 POS_W          = 4;
	localparam logic [3:0]         ADDR_W         = 4'h4;
	localparam logic [3:0]         CONFIG_OFFSET  = 4'h0;
	localparam logic [3:0]         MAP_OFFSET     = 4'h4;
	localparam logic [3:0]         STATUS_OFFSET  = 4'h8;
	localparam int                 CFG_MAPPED_LSB = 0;
	localparam int                 CFG_WRITE_LSB  = 4;
	localparam int                 CFG_ALT_BIT    = 8;
	localparam int                 CFG_CMW_BIT    = 9;
	localparam int                 ST_CONFLICT    = 0;
	localparam int                 ST_ENABLED     = 1;
	localparam int                 ST_SEEN        = 2;
	localparam int                 ST_SEL_LSB     = 4;
	localparam logic [31:0]        CONFIG_RESET   = 32'h0000_0000;
	localparam logic [31:0]        MAP_RESET      = 32'h0000_0000;
	localparam logic [1:0]         RESP_OKAY      = 2'h0;
	localparam logic [1:0]         RESP_DECERR    = 2'h3;
endpackage

// ---- dv/backplane_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module backplane_model (
	// clock
	input  wire logic  clk_i,
	// bus processor
	output logic [3:0] addr_hi_o,
	output logic       read_o,
	output logic       write_o,
	output logic       output_cycle_o,
	// memory management controller
	output logic       alt_select_n_o,
	output logic       cond_write_o
);
	initial begin
		addr_hi_o = 4'h0;
		read_o = 1'b0;
		write_o = 1'b0;
		output_cycle_o = 1'b0;
		alt_select_n_o = 1'b1;
		cond_write_o = 1'b0;
	end
	task automatic cycle(input logic [3:0] a, input logic r, input logic w);
		addr_hi_o <= a;
		read_o <= r;
		write_o <= w;
		repeat (2) @(posedge clk_i);
	endtask
	// released address lines show the inverse of the last value
	task automatic release_bus;
		read_o <= 1'b0;
		write_o <= 1'b0;
		addr_hi_o <= ~addr_hi_o;
	endtask
	task automatic ctl(input logic o, input logic a, input logic c);
		output_cycle_o <= o;
		alt_select_n_o <= a;
		cond_write_o <= c;
	endtask
endmodule // backplane_model
`default_nettype wire

// ---- dv/memory_board_bank_select_protect_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module memory_board_bank_select_protect_tb;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [3:0]  addr_hi_i, bank_select_n_o, bank_write_o, s_axi_awaddr, s_axi_araddr;
	logic        mem_read_i, mem_write_i, output_cycle_i, alternate_bank_select_n_i, conditional_write_line_i;
	logic        data_out_en_o, map_conflict_o, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          num_errors = 0;
	int          comparisons = 0;
	initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
	initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
	always #12.5 clk_i = ~clk_i;
	backplane_model pm (.clk_i(clk_i), .addr_hi_o(addr_hi_i), .read_o(mem_read_i), .write_o(mem_write_i),
		.output_cycle_o(output_cycle_i), .alt_select_n_o(alternate_bank_select_n_i),
		.cond_write_o(conditional_write_line_i));
	memory_board_bank_select_protect uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_hi_i(addr_hi_i),
		.mem_read_i(mem_read_i), .mem_write_i(mem_write_i), .output_cycle_i(output_cycle_i),
		.alternate_bank_select_n_i(alternate_bank_select_n_i), .conditional_write_line_i(conditional_write_line_i),
		.bank_select_n_o(bank_select_n_o), .bank_write_o(bank_write_o), .data_out_en_o(data_out_en_o),
		.map_conflict_o(map_conflict_o), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	task automatic chk(input bit ok, input string m);
		comparisons++;
		if (!ok) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic wrap_up;
		if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge clk_i);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp === er, "write response");
	endtask
	task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk_i);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge clk_i);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata === ed && s_axi_rresp === er, "read data");
	endtask
	task automatic bp(input logic [3:0] a, input logic r, w, input logic [3:0] es, ew, input logic eo);
		pm.cycle(a, r, w);
		#1;
		chk({bank_select_n_o, bank_write_o, data_out_en_o} === {es, ew, eo}, "backplane");
		@(posedge clk_i);
		pm.release_bus();
		@(posedge clk_i);
	endtask
	task automatic t_reset;
		chk({bank_select_n_o, bank_write_o, data_out_en_o, map_conflict_o} === 10'h3C0, "reset");
		axr(4'h0, 32'h0, 2'h0);
		axr(4'h4, 32'h0, 2'h0);
		bp(4'h0, 1'b0, 1'b1, 4'hF, 4'h0, 1'b0);
	endtask
	task automatic t_map;
		axw(4'h0, 32'h0000_001F, 2'h0);
		axw(4'h4, 32'h0000_95F0, 2'h0);
		axr(4'h4, 32'h0000_95F0, 2'h0);
		bp(4'h0, 1'b1, 1'b0, 4'hE, 4'h0, 1'b1);
		bp(4'hF, 1'b1, 1'b0, 4'hD, 4'h0, 1'b1);
		bp(4'h5, 1'b1, 1'b0, 4'hB, 4'h0, 1'b1);
		bp(4'h9, 1'b0, 1'b1, 4'h7, 4'h0, 1'b0);
		bp(4'h0, 1'b0, 1'b1, 4'hE, 4'h1, 1'b0);
		bp(4'h3, 1'b1, 1'b0, 4'hF, 4'h0, 1'b0);
	endtask
	task automatic t_out;
		pm.ctl(1'b1, 1'b1, 1'b0);
		bp(4'h0, 1'b0, 1'b1, 4'hF, 4'h0, 1'b0);
		pm.ctl(1'b0, 1'b1, 1'b0);
	endtask
	task automatic t_alt;
		axw(4'h0, 32'h0000_011F, 2'h0);
		bp(4'h0, 1'b1, 1'b0, 4'hF, 4'h0, 1'b0);
		pm.ctl(1'b0, 1'b0, 1'b0);
		bp(4'h0, 1'b1, 1'b0, 4'hE, 4'h0, 1'b1);
		pm.ctl(1'b0, 1'b1, 1'b0);
	endtask
	task automatic t_cmw;
		axw(4'h0, 32'h0000_021F, 2'h0);
		bp(4'h0, 1'b0, 1'b1, 4'hE, 4'h0, 1'b0);
		pm.ctl(1'b0, 1'b1, 1'b1);
		bp(4'h0, 1'b0, 1'b1, 4'hE, 4'h1, 1'b0);
	endtask
	task automatic t_dup;
		axw(4'h4, 32'h0000_9500, 2'h0);
		bp(4'h0, 1'b1, 1'b0, 4'hF, 4'h0, 1'b0);
		chk(map_conflict_o === 1'b1, "conflict flag");
		bp(4'h5, 1'b1, 1'b0, 4'hB, 4'h0, 1'b1);
		axr(4'h8, 32'h0000_0007, 2'h0);
		axw(4'h8, 32'h0000_0004, 2'h0);
		axr(4'h8, 32'h0000_0007, 2'h0);
	endtask
	task automatic t_decerr;
		axw(4'hC, 32'hFFFF_FFFF, 2'h3);
		axr(4'hC, 32'h0, 2'h3);
		axr(4'h4, 32'h0000_9500, 2'h0);
		axw(4'h4, 32'h0000_9510, 2'h0);
		axw(4'h8, 32'h0000_0004, 2'h0);
		axr(4'h8, 32'h0000_0002, 2'h0);
	endtask
	task automatic t_rerst;
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk({bank_select_n_o, bank_write_o, data_out_en_o, map_conflict_o} === 10'h3C0, "second reset");
		axr(4'h0, 32'h0, 2'h0);
		axr(4'h4, 32'h0, 2'h0);
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_reset();
		t_map();
		t_out();
		t_alt();
		t_cmw();
		t_dup();
		t_decerr();
		t_rerst();
		wrap_up();
	end
	initial begin
		repeat (3000) @(posedge clk_i);
		num_errors++;
		wrap_up();
	end
endmodule // memory_board_bank_select_protect_tb
`default_nettype wire
